/* logic/ogo_pkg.sv */
// Package of constants and types for the output gain and offset stage
package ogo_pkg;

  // Data widths
  localparam int SAMPLE_W = 18;
  localparam int REG_W = 16;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int LAT_W = 11;

  // Gain format: sign and magnitude, unity at 0x2000
  localparam int GAIN_SIGN_BIT = 15;
  localparam int GAIN_FRAC = 13;
  localparam logic [15:0] GAIN_UNITY = 16'h2000;
  localparam int OFFS_SHIFT = SAMPLE_W - REG_W;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PRIMARY_GAIN = 8'hf3;
  localparam logic [7:0] IDX_SECONDARY_GAIN = 8'hf4;
  localparam logic [7:0] IDX_CH0_I_OFFS = 8'hf5;
  localparam logic [7:0] IDX_CH0_Q_OFFS = 8'hf6;
  localparam logic [7:0] IDX_CH1_I_OFFS = 8'hf7;
  localparam logic [7:0] IDX_CH1_Q_OFFS = 8'hf8;
  localparam logic [7:0] IDX_MODE_CFG = 8'hf9;
  localparam logic [7:0] IDX_STATUS = 8'hfa;
  localparam logic [7:0] IDX_CANCEL_DLY = 8'hfb;

  // Reset values
  localparam logic [15:0] RST_GAIN = 16'h0000;
  localparam logic [15:0] RST_OFFS = 16'h0000;
  localparam logic [15:0] RST_CFG = 16'h0000;
  localparam logic [7:0] RST_CANCEL_DLY = 8'h00;

  // Mode register fields
  localparam int CFG_INTERP_LSB = 0;
  localparam int CFG_TWO_CHAN = 2;
  localparam int CFG_DECIM2 = 3;
  localparam int CFG_CLK_MODE = 4;
  localparam int CFG_CORE_LSB = 5;
  localparam int CFG_TX_LSB = 7;
  localparam int CFG_STAGE_LSB = 9;
  localparam int NUM_STAGES = 4;

  // Status register fields
  localparam int ST_CLK_OK = 11;
  localparam int ST_HALF_RATE = 12;

  // Latency figures in half samples: 1.5, 47.5 and 16.5 samples
  localparam logic [13:0] LAT_DIS_HALF = 14'h0003;
  localparam logic [13:0] LAT_EN_HALF = 14'h005f;
  localparam logic [13:0] LAT_FIX_HALF = 14'h0021;

  // Interpolation modes
  typedef enum logic [1:0] {
    OGO_INTERP_NONE = 2'b00,
    OGO_INTERP_2X_CPLX = 2'b01,
    OGO_INTERP_2X_REAL = 2'b10,
    OGO_INTERP_4X_REAL = 2'b11
  } ogo_interp_type;

  // Clock ratio codes
  localparam logic [1:0] RATIO_1X = 2'b00;
  localparam logic [1:0] RATIO_2X = 2'b01;
  localparam logic [1:0] RATIO_4X = 2'b10;

  // Bus slave states, Gray along the path
  typedef enum logic [1:0] {
    OGO_BUS_IDLE = 2'b00,
    OGO_BUS_ACK = 2'b01
  } ogo_bus_type;

endpackage : ogo_pkg

/* logic/ogo_lane.sv */
// One sample lane: sign-magnitude gain, dc offset and saturation
`timescale 1ns/10ps
`default_nettype none
module ogo_lane (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Sample in
  input wire logic in_valid,
  input wire logic [ogo_pkg::SAMPLE_W-1:0] sample,
  // Settings
  input wire logic [ogo_pkg::REG_W-1:0] gain,
  input wire logic [ogo_pkg::REG_W-1:0] offset,
  // Sample out
  output logic [ogo_pkg::SAMPLE_W-1:0] result_q
);

  localparam int PROD_W = ogo_pkg::SAMPLE_W + ogo_pkg::REG_W;
  localparam int SCL_W = PROD_W - ogo_pkg::GAIN_FRAC;
  localparam int SUM_W = SCL_W + 2;
  localparam logic signed [SUM_W-1:0] SAT_MAX =
    SUM_W'(signed'(2 ** (ogo_pkg::SAMPLE_W - 1) - 1));
  localparam logic signed [SUM_W-1:0] SAT_MIN =
    SUM_W'(signed'(-(2 ** (ogo_pkg::SAMPLE_W - 1))));

  logic signed [PROD_W-1:0] prod;
  logic signed [SCL_W-1:0] scaled;
  logic signed [SUM_W-1:0] signed_gain;
  logic signed [SUM_W-1:0] offs_ext;
  logic signed [SUM_W-1:0] sum;
  logic [ogo_pkg::SAMPLE_W-1:0] result_d;

  // Magnitude multiply, then apply the sign bit as a phase inversion
  always_comb begin
    prod = $signed(sample) * $signed({1'b0, gain[ogo_pkg::GAIN_SIGN_BIT-1:0]});
    scaled = prod[PROD_W-1:ogo_pkg::GAIN_FRAC];
    if (gain[ogo_pkg::GAIN_SIGN_BIT]) begin
      signed_gain = -SUM_W'(scaled);
    end else begin
      signed_gain = SUM_W'(scaled);
    end
    // Offset sits on the upper bits of the sample word
    offs_ext = SUM_W'($signed({offset, {ogo_pkg::OFFS_SHIFT{1'b0}}}));
    sum = signed_gain + offs_ext;
    // Clip instead of wrapping when boost or offset overflows
    if (sum > SAT_MAX) begin
      result_d = SAT_MAX[ogo_pkg::SAMPLE_W-1:0];
    end else if (sum < SAT_MIN) begin
      result_d = SAT_MIN[ogo_pkg::SAMPLE_W-1:0];
    end else begin
      result_d = sum[ogo_pkg::SAMPLE_W-1:0];
    end
  end

  // Output word holds between samples
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= '0;
    end else if (in_valid) begin
      result_q <= result_d;
    end
  end

endmodule : ogo_lane
`default_nettype wire

/* logic/ogo_stage.sv */
// Output gain and offset stage with Avalon-MM register slave
// Summary of operation
// - Bit 15 of each port gain is a sign; set inverts the port's phase.
// - Results beyond the 18-bit range clip instead of wrapping.
// - Channel-0 I offset is added to port A I samples, sole I offset in one-channel use.
// - Each offset is signed 16-bit, aligned to the top 16 bits of the sample.
// - In 2x or 4x real output, channel-0 I offset applies to channel-0 real samples.
// - Channel-0 Q offset is added to port A Q samples, sole Q offset in one-channel use.
// - In two-channel use the channel-1 I offset goes to port B I samples.
// - In 2x or 4x real output, channel-1 I offset applies to channel-1 real samples.
// - In two-channel use the channel-1 Q offset goes to port B Q samples.
// - All four offsets are read/write and clear to zero at reset.
// - Latency is 1.5 per disabled stage, delay plus 47.5 per enabled one, plus 16.5.
// - A fractional latency rounds up to the next whole sample.
// - With 2x decimation and 2x interpolation rates match and stages run half rate.
// - First clock mode runs core at 4x and transmit at 1x, 2x or 4x.
// - Second clock mode runs core at 1x or 2x, transmit 1x, or 2x only with 2x core.
// - Gain 0x2000 is unity and gains reset to zero so outputs start at zero.
`timescale 1ns/10ps
`default_nettype none
module ogo_stage (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [ogo_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [ogo_pkg::DATA_W-1:0] avs_writedata,
  output logic [ogo_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Samples in from the interpolator
  input wire logic in_valid,
  input wire logic [ogo_pkg::SAMPLE_W-1:0] in_a_i,
  input wire logic [ogo_pkg::SAMPLE_W-1:0] in_a_q,
  input wire logic [ogo_pkg::SAMPLE_W-1:0] in_b_i,
  input wire logic [ogo_pkg::SAMPLE_W-1:0] in_b_q,
  // Samples out to the converter
  output logic out_valid,
  output logic [ogo_pkg::SAMPLE_W-1:0] out_a_i,
  output logic [ogo_pkg::SAMPLE_W-1:0] out_a_q,
  output logic [ogo_pkg::SAMPLE_W-1:0] out_b_i,
  output logic [ogo_pkg::SAMPLE_W-1:0] out_b_q,
  // Clocking and rate status
  output logic [2:0] core_mult,
  output logic [2:0] tx_mult,
  output logic clock_cfg_ok,
  output logic stage_half_rate
);

  // Lanes in port order: A I, A Q, B I, B Q
  localparam int NL = 4;

  // Register state
  logic [ogo_pkg::REG_W-1:0] gain_q [2];
  logic [ogo_pkg::REG_W-1:0] offs_q [NL];
  logic [ogo_pkg::REG_W-1:0] cfg_q;
  logic [7:0] cancel_dly_q;
  logic [ogo_pkg::LAT_W-1:0] latency_q;
  ogo_pkg::ogo_bus_type bus_q;
  logic [ogo_pkg::DATA_W-1:0] rdata_q;
  logic wait_q;
  logic valid_q;
  logic [2:0] core_q;
  logic [2:0] tx_q;
  logic clk_ok_q;
  logic half_q;

  // Decoded bus access
  logic [7:0] idx;
  logic wr_fire;
  logic [ogo_pkg::REG_W-1:0] wmask;
  logic [ogo_pkg::REG_W-1:0] rd_word;
  logic [ogo_pkg::REG_W-1:0] status_word;

  assign idx = avs_address[ogo_pkg::ADDR_W-1:2];
  assign wr_fire = avs_write && (bus_q == ogo_pkg::OGO_BUS_ACK);
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Bus handshake: request seen, then one cycle later waitrequest drops
  // Waitrequest idles high so a request is never answered in the cycle
  // it first appears; the read word is registered at the edge that sees
  // the request, so it stands when waitrequest drops.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_q <= ogo_pkg::OGO_BUS_IDLE;
      wait_q <= 1'b1;
    end else begin
      case (bus_q)
        ogo_pkg::OGO_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= ogo_pkg::OGO_BUS_ACK;
            wait_q <= 1'b0;
          end
        end
        ogo_pkg::OGO_BUS_ACK: begin
          bus_q <= ogo_pkg::OGO_BUS_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          bus_q <= ogo_pkg::OGO_BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // Status word built from live state
  // Bits above the status fields read as zero
  always_comb begin
    status_word = '0;
    status_word[ogo_pkg::LAT_W-1:0] = latency_q;
    status_word[ogo_pkg::ST_CLK_OK] = clk_ok_q;
    status_word[ogo_pkg::ST_HALF_RATE] = half_q;
  end

  // Read mux; unmapped words read as zero
  // The status index has no write path, so writes to it fall away
  always_comb begin
    case (idx)
      ogo_pkg::IDX_PRIMARY_GAIN: rd_word = gain_q[0];
      ogo_pkg::IDX_SECONDARY_GAIN: rd_word = gain_q[1];
      ogo_pkg::IDX_CH0_I_OFFS: rd_word = offs_q[0];
      ogo_pkg::IDX_CH0_Q_OFFS: rd_word = offs_q[1];
      ogo_pkg::IDX_CH1_I_OFFS: rd_word = offs_q[2];
      ogo_pkg::IDX_CH1_Q_OFFS: rd_word = offs_q[3];
      ogo_pkg::IDX_MODE_CFG: rd_word = cfg_q;
      ogo_pkg::IDX_STATUS: rd_word = status_word;
      ogo_pkg::IDX_CANCEL_DLY: rd_word = {8'h00, cancel_dly_q};
      default: rd_word = '0;
    endcase
  end

  // Read data captured early so it stands when waitrequest is low
  // A master that drops read before waitrequest falls still leaves the word
  // of that read here, captured at the edge that first saw it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (avs_read && bus_q == ogo_pkg::OGO_BUS_IDLE) begin
      rdata_q <= {16'h0000, rd_word};
    end
  end

  // Gain registers start at zero so ports emit zeros until programmed
  // Byte enables merge into the old value, so a half-word write keeps
  // the other byte as it was
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_q[0] <= ogo_pkg::RST_GAIN;
      gain_q[1] <= ogo_pkg::RST_GAIN;
    end else if (wr_fire) begin
      if (idx == ogo_pkg::IDX_PRIMARY_GAIN) begin
        gain_q[0] <= (gain_q[0] & ~wmask) | (avs_writedata[15:0] & wmask);
      end
      if (idx == ogo_pkg::IDX_SECONDARY_GAIN) begin
        gain_q[1] <= (gain_q[1] & ~wmask) | (avs_writedata[15:0] & wmask);
      end
    end
  end

  // Offset registers, one per lane, cleared at reset
  // A new offset reaches the next sample only; a word already held in a
  // lane register keeps the offset it was built with
  for (genvar k = 0; k < NL; k++) begin : g_offs
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        offs_q[k] <= ogo_pkg::RST_OFFS;
      end else if (wr_fire && idx == ogo_pkg::IDX_CH0_I_OFFS + 8'(k)) begin
        offs_q[k] <= (offs_q[k] & ~wmask) | (avs_writedata[15:0] & wmask);
      end
    end
  end

  // Mode and cancel delay registers
  // Cancel delay is one byte wide; its upper byte lane is ignored
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= ogo_pkg::RST_CFG;
      cancel_dly_q <= ogo_pkg::RST_CANCEL_DLY;
    end else if (wr_fire) begin
      if (idx == ogo_pkg::IDX_MODE_CFG) begin
        cfg_q <= (cfg_q & ~wmask) | (avs_writedata[15:0] & wmask);
      end
      if (idx == ogo_pkg::IDX_CANCEL_DLY && avs_byteenable[0]) begin
        cancel_dly_q <= avs_writedata[7:0];
      end
    end
  end

  // Mode decode
  ogo_pkg::ogo_interp_type interp;
  logic two_chan;
  logic real_out;
  logic [ogo_pkg::NUM_STAGES-1:0] stage_en;

  assign interp = ogo_pkg::ogo_interp_type'(cfg_q[ogo_pkg::CFG_INTERP_LSB +: 2]);
  assign two_chan = cfg_q[ogo_pkg::CFG_TWO_CHAN];
  assign real_out = (interp == ogo_pkg::OGO_INTERP_2X_REAL) ||
                    (interp == ogo_pkg::OGO_INTERP_4X_REAL);
  assign stage_en = cfg_q[ogo_pkg::CFG_STAGE_LSB +: ogo_pkg::NUM_STAGES];

  // Latency in half samples, rounded up to whole samples
  // Half samples keep the .5 figures exact; adding one before halving
  // rounds a fractional result up. The status value lags a mode write
  // by one cycle.
  logic [2:0] n_en;
  logic [13:0] lat_half;
  always_comb begin
    n_en = '0;
    for (int s = 0; s < ogo_pkg::NUM_STAGES; s++) begin
      n_en = n_en + 3'(stage_en[s]);
    end
    lat_half = 14'(3'(ogo_pkg::NUM_STAGES) - n_en) * ogo_pkg::LAT_DIS_HALF
             + 14'(n_en) * ({5'h00, cancel_dly_q, 1'b0} + ogo_pkg::LAT_EN_HALF)
             + ogo_pkg::LAT_FIX_HALF;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latency_q <= '0;
    end else begin
      latency_q <= ogo_pkg::LAT_W'((lat_half + 14'h0001) >> 1);
    end
  end

  // Clock ratio and rate status
  // An illegal selection clears the ok flag and the transmit multiple
  // falls back to 1x rather than showing a rate the clocking cannot
  // make; software must poll the flag after changing ratios.
  logic [1:0] core_sel;
  logic [1:0] tx_sel;
  logic [2:0] core_d;
  logic [2:0] tx_d;
  logic ok_d;
  assign core_sel = cfg_q[ogo_pkg::CFG_CORE_LSB +: 2];
  assign tx_sel = cfg_q[ogo_pkg::CFG_TX_LSB +: 2];

  always_comb begin
    tx_d = 3'(1) << tx_sel;
    if (!cfg_q[ogo_pkg::CFG_CLK_MODE]) begin
      // First mode: core pinned at 4x, transmit any of 1x, 2x, 4x
      core_d = 3'h4;
      ok_d = (tx_sel != 2'b11);
    end else begin
      // Second mode: core 1x or 2x; 2x transmit needs 2x core
      core_d = (core_sel == ogo_pkg::RATIO_2X) ? 3'h2 : 3'h1;
      ok_d = ((core_sel == ogo_pkg::RATIO_1X) ||
              (core_sel == ogo_pkg::RATIO_2X)) &&
             ((tx_sel == ogo_pkg::RATIO_1X) ||
              (tx_sel == ogo_pkg::RATIO_2X &&
               core_sel == ogo_pkg::RATIO_2X));
    end
    if (!ok_d) begin
      tx_d = 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_q <= 3'h4;
      tx_q <= 3'h1;
      clk_ok_q <= 1'b1;
      half_q <= 1'b0;
    end else begin
      core_q <= core_d;
      tx_q <= tx_d;
      clk_ok_q <= ok_d;
      // Decimate and interpolate together: equal rates, stages at half
      half_q <= cfg_q[ogo_pkg::CFG_DECIM2] &&
                (interp != ogo_pkg::OGO_INTERP_NONE);
    end
  end

  // Offset routing per lane: 0 = A I, 1 = A Q, 2 = B I, 3 = B Q
  // In one-channel use port B mirrors the channel-0 offsets, so a stray
  // second-port stream still sees a defined correction
  logic [ogo_pkg::REG_W-1:0] lane_offs [NL];
  logic [ogo_pkg::SAMPLE_W-1:0] lane_in [NL];
  logic [ogo_pkg::SAMPLE_W-1:0] lane_out [NL];

  assign lane_in[0] = in_a_i;
  assign lane_in[1] = in_a_q;
  assign lane_in[2] = in_b_i;
  assign lane_in[3] = in_b_q;

  always_comb begin
    lane_offs[0] = offs_q[0];
    lane_offs[1] = offs_q[1];
    lane_offs[2] = offs_q[0];
    lane_offs[3] = offs_q[1];
    if (two_chan) begin
      lane_offs[2] = offs_q[2];
      lane_offs[3] = offs_q[3];
    end
    // Real output: every word of a channel takes its I offset
    if (real_out) begin
      lane_offs[1] = offs_q[0];
      lane_offs[2] = two_chan ? offs_q[2] : offs_q[0];
      lane_offs[3] = two_chan ? offs_q[2] : offs_q[0];
    end
  end

  // Four identical lanes; port A uses the primary gain
  // Lane k takes gain k/2, so both words of a port share one gain and
  // a negative code inverts the whole port
  for (genvar k = 0; k < NL; k++) begin : g_lane
    ogo_lane u_lane (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .in_valid(in_valid),
      .sample(lane_in[k]),
      .gain(gain_q[k / 2]),
      .offset(lane_offs[k]),
      .result_q(lane_out[k])
    );
  end

  // Output valid tracks the lane register
  // Valid is one cycle behind the strobe, matching the lane register,
  // so the converter never latches a word that is still changing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= in_valid;
    end
  end

  // Every output is a register; no logic sits between flops and ports
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign out_valid = valid_q;
  assign out_a_i = lane_out[0];
  assign out_a_q = lane_out[1];
  assign out_b_i = lane_out[2];
  assign out_b_q = lane_out[3];
  assign core_mult = core_q;
  assign tx_mult = tx_q;
  assign clock_cfg_ok = clk_ok_q;
  assign stage_half_rate = half_q;

endmodule : ogo_stage
`default_nettype wire

/* testbench/ogo_stage_assertions.sv */
// Port checker for the output gain and offset stage
`timescale 1ns/10ps
`default_nettype none
module ogo_stage_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ogo_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Samples
  input wire logic in_valid,
  input wire logic out_valid,
  input wire logic [ogo_pkg::SAMPLE_W-1:0] out_a_i,
  input wire logic [ogo_pkg::SAMPLE_W-1:0] out_a_q,
  input wire logic [ogo_pkg::SAMPLE_W-1:0] out_b_i,
  input wire logic [ogo_pkg::SAMPLE_W-1:0] out_b_q,
  // Clock ratios
  input wire logic [2:0] core_mult,
  input wire logic [2:0] tx_mult
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic wr_seen_q;
  // Any write may open a gain, so zero output is only owed before one
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) wr_seen_q <= 1'b0;
    else if (avs_write) wr_seen_q <= 1'b1;
  end
  property p_vld; in_valid |=> out_valid; endproperty
  a_vld: assert property (p_vld) else $error("no out_valid");
  property p_nvld; !in_valid |=> !out_valid; endproperty
  a_nvld: assert property (p_nvld) else $error("stray out_valid");
  property p_hold;
    !in_valid |=> $stable(out_a_i) && $stable(out_a_q)
      && $stable(out_b_i) && $stable(out_b_q);
  endproperty
  a_hold: assert property (p_hold) else $error("samples moved");
  property p_ack; (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("late answer");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_hi; !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
  endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_zero; out_valid && !wr_seen_q |-> out_a_i == 0
    && out_a_q == 0 && out_b_i == 0 && out_b_q == 0; endproperty
  a_zero: assert property (p_zero) else $error("output not zero");
  property p_tx4; tx_mult == 3'h4 |-> core_mult == 3'h4; endproperty
  a_tx4: assert property (p_tx4) else $error("tx 4x bad core");
  property p_tx2; tx_mult == 3'h2 |-> core_mult != 3'h1; endproperty
  a_tx2: assert property (p_tx2) else $error("tx 2x bad core");
  c_rd: cover property (avs_read && !avs_waitrequest);
  c_sat: cover property (out_valid && out_a_i == 18'h1_ffff);
  c_b: cover property (out_valid && out_b_q != 0);
endmodule : ogo_stage_chk
bind ogo_stage ogo_stage_chk u_chk (.ref_clk, .arst_n, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .in_valid, .out_valid,
  .out_a_i, .out_a_q, .out_b_i, .out_b_q, .core_mult, .tx_mult);
`default_nettype wire

/* testbench/ogo_dac_model.sv */
// Converter model that captures each output sample
`timescale 1ns/10ps
`default_nettype none
module ogo_dac_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Samples from the stage
  input wire logic out_valid,
  input wire logic [0:3][ogo_pkg::SAMPLE_W-1:0] smp,
  // Captured samples
  output logic [0:3][ogo_pkg::SAMPLE_W-1:0] cap_q
);
  // Latch on the strobe only, held values are not new conversions
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) cap_q <= '0;
    else if (out_valid) cap_q <= smp;
  end
endmodule : ogo_dac_model
`default_nettype wire

/* testbench/output_gain_offset_stage_tb_top.sv */
// Self-checking bench for the output gain and offset stage
`timescale 1ns/10ps
`default_nettype none
module output_gain_offset_stage_tb_top;
  typedef logic [0:3][ogo_pkg::SAMPLE_W-1:0] ogo_quad_type;
  typedef struct {
    logic [15:0] cfg;
    logic [15:0] ga;
    logic [15:0] gb;
    logic [0:3][15:0] off;
    logic [17:0] x;
  } ogo_row_type;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [9:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic in_valid = 1'b0;
  ogo_quad_type in_s = '0;
  wire ogo_quad_type out_s;
  ogo_quad_type cap;
  logic out_valid;
  logic [2:0] core_mult;
  logic [2:0] tx_mult;
  logic clock_cfg_ok;
  logic stage_half_rate;
  int n_fail = 0;
  int comparisons = 0;
  ogo_row_type rows [5] = '{
    '{16'h0004, 16'h2000, 16'h2000, '{0, 0, 0, 0}, 18'h1_2345},
    '{16'h0004, 16'ha000, 16'h4000,
      '{16'h0010, 16'hfff0, 16'h0100, 16'h8000}, 18'h0_0abc},
    '{16'h0000, 16'h7fff, 16'hffff, '{16'h7fff, 1, 2, 3}, 18'h1_ffff},
    '{16'h0006, 16'h2000, 16'h1fff,
      '{16'h0100, 16'h0200, 16'h0300, 16'h0400}, 18'h2_0000},
    '{16'h0003, 16'h3fff, 16'h2000,
      '{16'h8000, 16'h7fff, 16'h1234, 16'h4321}, 18'h3_fffe}};
  logic [0:4][15:0] ck_row = '{16'h0100, 16'h0180, 16'h00b0, 16'h0090,
    16'h0058};
  logic [0:4][6:0] ck_exp = '{7'h49, 7'h42, 7'h25, 7'h12, 7'h12};

  ogo_stage dut (.ref_clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .in_valid, .in_a_i(in_s[0]), .in_a_q(in_s[1]), .in_b_i(in_s[2]),
    .in_b_q(in_s[3]), .out_valid, .out_a_i(out_s[0]), .out_a_q(out_s[1]),
    .out_b_i(out_s[2]), .out_b_q(out_s[3]), .core_mult, .tx_mult,
    .clock_cfg_ok, .stage_half_rate);
  ogo_dac_model u_dac (.ref_clk, .arst_n, .out_valid, .smp(out_s),
    .cap_q(cap));

  // 20 MHz reference
  always #25 ref_clk = ~ref_clk;

  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_smp(logic [17:0] g, logic [17:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_smp

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(logic wr, logic [7:0] idx, logic [15:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    // No local limit: only the watchdog ends a hung handshake
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(logic [7:0] idx, logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(logic [7:0] idx, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 16'h0000, q);
    chk(q, e);
  endtask : rd

  // One sample strobe, then wait until the converter has latched it
  task automatic send(ogo_quad_type xs);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_s <= xs;
    @(posedge ref_clk);
    in_valid <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : send

  // Reference lane: floor of the product, sign, offset, clip to 18 bits
  function automatic logic [17:0] lane(logic [17:0] x, logic [15:0] g,
                                       logic [15:0] o);
    longint p;
    p = (longint'($signed(x)) * longint'(g[14:0])) >>> 13;
    if (g[15]) p = -p;
    p = p + longint'($signed(o)) * 4;
    if (p > 131071) p = 131071;
    if (p < -131072) p = -131072;
    return p[17:0];
  endfunction : lane

  initial begin
    ogo_row_type r;
    ogo_quad_type xs;
    logic [15:0] g;
    int k;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(ogo_pkg::IDX_STATUS, 32'h0000_0817);
    // Table rows: gains, offsets and routing per mode
    foreach (rows[i]) begin
      r = rows[i];
      wr(ogo_pkg::IDX_MODE_CFG, r.cfg);
      wr(ogo_pkg::IDX_PRIMARY_GAIN, r.ga);
      wr(ogo_pkg::IDX_SECONDARY_GAIN, r.gb);
      for (int j = 0; j < 4; j++) wr(ogo_pkg::IDX_CH0_I_OFFS + 8'(j), r.off[j]);
      xs = '{r.x, ~r.x, r.x ^ 18'h2_aaaa, -r.x};
      send(xs);
      for (int j = 0; j < 4; j++) begin
        g = (j < 2) ? r.ga : r.gb;
        k = ((j > 1) && r.cfg[2]) ? 2 : 0;
        if (!r.cfg[1]) k = k + j % 2;
        chk_smp(cap[j], lane(xs[j], g, r.off[k]));
      end
    end
    for (int j = 0; j < 4; j++) rd(ogo_pkg::IDX_CH0_I_OFFS + 8'(j), {16'h0000, r.off[j]});
    // Unmapped place and read-only status
    wr(8'h10, 16'hbeef);
    rd(8'h10, 32'h0000_0000);
    wr(ogo_pkg::IDX_CANCEL_DLY, 16'h0003);
    wr(ogo_pkg::IDX_MODE_CFG, 16'h0a00);
    wr(ogo_pkg::IDX_STATUS, 16'h0000);
    rd(ogo_pkg::IDX_STATUS, 32'h0000_0879);
    wr(ogo_pkg::IDX_MODE_CFG, 16'h0009);
    rd(ogo_pkg::IDX_STATUS, 32'h0000_1817);
    chk(32'(stage_half_rate), 32'h1);
    // Clock ratio selections, legal and illegal
    for (int j = 0; j < 5; j++) begin
      wr(ogo_pkg::IDX_MODE_CFG, ck_row[j]);
      repeat (2) @(posedge ref_clk);
      chk(32'({core_mult, tx_mult, clock_cfg_ok}), 32'(ck_exp[j]));
      chk(32'(stage_half_rate), 32'h0);
    end
    // Byte lanes: only the low byte may change
    wr(ogo_pkg::IDX_CH1_Q_OFFS, 16'hffff);
    avs_byteenable <= 4'h1;
    wr(ogo_pkg::IDX_CH1_Q_OFFS, 16'h1234);
    avs_byteenable <= 4'hf;
    rd(ogo_pkg::IDX_CH1_Q_OFFS, 32'h0000_ff34);
    // Second reset in mid-run clears offsets and gains
    arst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int j = 0; j < 4; j++) rd(ogo_pkg::IDX_CH0_I_OFFS + 8'(j), 32'h0);
    send('{18'h1_0000, 18'h0_1234, 18'h3_0000, 18'h0_0001});
    for (int j = 0; j < 4; j++) chk_smp(cap[j], 18'h0_0000);
    finish_test();
  end

  // Watchdog far beyond the few hundred cycles the run needs
  initial begin
    #(50 * 40000);
    n_fail++;
    finish_test();
  end
endmodule : output_gain_offset_stage_tb_top
`default_nettype wire
